// File: design/vpic_ctrl.sv
/*
  Vectored priority interrupt controller top: register file, request
  flags, trap flags, pending vector latch and cpu priority level.
  Assumes peripheral requests and trap inputs are one-cycle pulses on
  core_clk_in and the core acknowledges a vector with ack_in.
*/
`timescale 1ns/100ps
module vpic_ctrl
  import vpic_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic [NUM_SRC-1:0] periph_req_in,
  input wire logic [NUM_EXT-1:0] ext_pin_in,
  input wire logic [NUM_TRAP-1:0] trap_in,
  input wire logic ack_in,
  input wire logic restore_in,
  input wire logic [3:0] restore_level_in,
  output logic int_req_out,
  output logic [6:0] vector_num_out,
  output logic [3:0] pending_level_out,
  output logic [23:0] vector_addr_out,
  output logic [3:0] cpu_level_out,
  output logic irq_out
);
  logic [15:0] gc1_q;
  logic [15:0] gc2_q;
  logic [NUM_SRC-1:0] flag_q;
  logic [NUM_SRC-1:0] flag_d;
  logic [NUM_SRC-1:0] en_q;
  logic [NUM_SRC-1:0] en_d;
  logic [2:0] prio_q [NUM_SRC];
  logic [2:0] prio_d [NUM_SRC];
  logic [2:0] cpu_low_q;
  logic cpu_high_q;
  logic int_req_q;
  logic [6:0] vec_q;
  logic [3:0] lvl_q;
  logic [EVT_W-1:0] evt_st_q;
  logic [EVT_W-1:0] evt_msk_q;
  logic [15:0] rdata_q;
  logic [15:0] rd_mux;
  logic [NUM_EXT-1:0] ext_edge;
  logic [NUM_SRC-1:0] ext_set;
  logic [NUM_SRC-1:0] src_set;
  logic [NUM_FLAG_REG-1:0] flag_wr;
  logic [NUM_FLAG_REG-1:0] en_wr;
  logic [NUM_PRI_REG-1:0] pri_wr;
  logic [15:0] flag_word [NUM_FLAG_REG];
  logic [15:0] en_word [NUM_FLAG_REG];
  logic [15:0] pri_word [NUM_PRI_REG];
  logic trap_found;
  logic [6:0] trap_vec;
  logic [3:0] trap_lvl;
  logic any_found;
  logic [6:0] next_vec;
  logic [3:0] next_lvl;
  logic ack_take;
  logic [EVT_W-1:0] evt_set;
  logic [3:0] cpu_level;

  vpic_arb_if ab ();

  // Register strobes
  wire gc1_wr = reg_wr_in && reg_addr_in == A_GC1;
  wire gc2_wr = reg_wr_in && reg_addr_in == A_GC2;
  wire sr_wr = reg_wr_in && reg_addr_in == A_SR;
  wire est_wr = reg_wr_in && reg_addr_in == A_EVT_ST;
  wire emsk_wr = reg_wr_in && reg_addr_in == A_EVT_MSK;
  wire nest_dis = gc1_q[NEST_DIS_BIT];
  wire alt_sel = gc2_q[ALT_SEL_BIT];
  wire [NUM_TRAP-1:0] trap_flags = gc1_q[TRAP_LSB +: NUM_TRAP];

  assign cpu_level = {cpu_high_q, cpu_low_q};
  assign ack_take = ack_in && int_req_q;

  // External pins, each with its own polarity select
  for (genvar e = 0; e < NUM_EXT; e++) begin : g_ext
    vpic_pin_edge u_edge (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .pin_in(ext_pin_in[e]),
      .neg_sel_in(gc2_q[e]),
      .edge_out(ext_edge[e])
    );
  end

  always_comb begin
    ext_set = '0;
    for (int e = 0; e < NUM_EXT; e++) begin
      ext_set[EXT_REQ[e]] = ext_edge[e];
    end
  end
  assign src_set = periph_req_in | ext_set;

  // Word decode for flag, enable and priority banks
  for (genvar k = 0; k < NUM_FLAG_REG; k++) begin : g_fw
    assign flag_wr[k] = reg_wr_in && reg_addr_in == A_FLAG0 + 6'(k);
    assign en_wr[k] = reg_wr_in && reg_addr_in == A_EN0 + 6'(k);
  end
  for (genvar k = 0; k < NUM_PRI_REG; k++) begin : g_pw
    assign pri_wr[k] = reg_wr_in && reg_addr_in == A_PRI0 + 6'(k);
  end

  // Source i sits at bit i%16 of word i/16, priority at nibble i%4
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    localparam int W = i / 16;
    localparam int B = i % 16;
    localparam int P = i / 4;
    localparam int N = (i % 4) * 4;
    // A source pulse in the clearing cycle still sets the flag
    assign flag_d[i] = (flag_wr[W] ? reg_wdata_in[B] : flag_q[i]) | src_set[i];
    assign en_d[i] = en_wr[W] ? reg_wdata_in[B] : en_q[i];
    assign prio_d[i] = pri_wr[P] ? reg_wdata_in[N +: 3] : prio_q[i];
    assign ab.prio[i] = prio_q[i];
  end

  // Read-back words; bits of unused request numbers 72 up read zero
  for (genvar k = 0; k < NUM_FLAG_REG; k++) begin : g_rw
    wire [79:0] fl = {8'h00, flag_q};
    wire [79:0] en = {8'h00, en_q};
    assign flag_word[k] = fl[k*16 +: 16];
    assign en_word[k] = en[k*16 +: 16];
  end
  for (genvar k = 0; k < NUM_PRI_REG; k++) begin : g_rp
    assign pri_word[k] = {1'b0, prio_q[4*k+3], 1'b0, prio_q[4*k+2],
                          1'b0, prio_q[4*k+1], 1'b0, prio_q[4*k]};
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_q <= '0;
      en_q <= '0;
      for (int i = 0; i < NUM_SRC; i++) begin
        prio_q[i] <= PRIO_RST;
      end
    end else begin
      flag_q <= flag_d;
      en_q <= en_d;
      prio_q <= prio_d;
    end
  end

  assign ab.req = flag_q & en_q;
  assign ab.cpu_level = cpu_level;

  vpic_arbiter u_arb (
    .bus(ab)
  );

  // Traps outrank every user level; lowest trap vector wins
  always_comb begin
    trap_found = 1'b0;
    trap_vec = 7'h00;
    trap_lvl = 4'h0;
    for (int t = NUM_TRAP - 1; t >= 0; t--) begin
      if (trap_flags[t] && 4'(15 - TRAP_VEC[t]) > cpu_level &&
          (!trap_found || 7'(TRAP_VEC[t]) < trap_vec)) begin
        trap_found = 1'b1;
        trap_vec = 7'(TRAP_VEC[t]);
        trap_lvl = 4'(15 - TRAP_VEC[t]);
      end
    end
  end

  assign any_found = trap_found || ab.found;
  assign next_vec = trap_found ? trap_vec : ab.irq_num + VEC_OFS;
  assign next_lvl = trap_found ? trap_lvl : {1'b0, ab.level};

  // Pending vector latch
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      int_req_q <= 1'b0;
      vec_q <= 7'h00;
      lvl_q <= 4'h0;
    end else begin
      int_req_q <= any_found;
      if (any_found) begin
        vec_q <= next_vec;
        lvl_q <= next_lvl;
      end
    end
  end

  // Trap flags are set by hardware and cleared by software writes
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gc1_q <= GC_RST;
      gc2_q <= GC_RST;
    end else begin
      gc1_q <= ((gc1_wr ? reg_wdata_in : gc1_q) & GC1_WMASK) |
               16'({trap_in, 1'b0});
      if (gc2_wr) begin
        gc2_q <= reg_wdata_in & GC2_WMASK;
      end
    end
  end

  // Core side level changes take precedence over software writes
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cpu_low_q <= CPU_LOW_RST;
      cpu_high_q <= CPU_HIGH_RST;
    end else if (restore_in) begin
      cpu_low_q <= restore_level_in[2:0];
      cpu_high_q <= restore_level_in[3];
    end else if (ack_take) begin
      cpu_low_q <= lvl_q[2:0];
      cpu_high_q <= lvl_q[3];
    end else if (sr_wr && !nest_dis) begin
      cpu_low_q <= reg_wdata_in[IPL_LSB +: 3];
    end
  end

  // Block events: new pending vector, trap flagged
  assign evt_set[EVT_NEW] = any_found && (!int_req_q || next_vec != vec_q);
  assign evt_set[EVT_TRAP] = |trap_in;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      evt_st_q <= '0;
      evt_msk_q <= '0;
    end else begin
      evt_st_q <= (evt_st_q & ~(est_wr ? reg_wdata_in[EVT_W-1:0] : '0)) | evt_set;
      if (emsk_wr) begin
        evt_msk_q <= reg_wdata_in[EVT_W-1:0];
      end
    end
  end

  // Read mux; the core control word only reflects the high level bit
  always_comb begin
    rd_mux = 16'h0000;
    if (reg_addr_in == A_GC1) begin
      rd_mux = gc1_q;
    end else if (reg_addr_in == A_GC2) begin
      rd_mux = gc2_q;
    end else if (reg_addr_in >= A_FLAG0 && reg_addr_in < A_EN0) begin
      rd_mux = flag_word[3'(reg_addr_in - A_FLAG0)];
    end else if (reg_addr_in >= A_EN0 && reg_addr_in < A_PRI0) begin
      rd_mux = en_word[3'(reg_addr_in - A_EN0)];
    end else if (reg_addr_in >= A_PRI0 && reg_addr_in < A_PEND) begin
      rd_mux = pri_word[5'(reg_addr_in - A_PRI0)];
    end else if (reg_addr_in == A_PEND) begin
      rd_mux = {4'h0, lvl_q, 1'b0, vec_q};
    end else if (reg_addr_in == A_SR) begin
      rd_mux = 16'({cpu_low_q, 5'h00});
    end else if (reg_addr_in == A_CORE) begin
      rd_mux = 16'({cpu_high_q, 3'h0});
    end else if (reg_addr_in == A_EVT_ST) begin
      rd_mux = 16'(evt_st_q);
    end else if (reg_addr_in == A_EVT_MSK) begin
      rd_mux = 16'(evt_msk_q);
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign int_req_out = int_req_q;
  assign vector_num_out = vec_q;
  assign pending_level_out = lvl_q;
  assign vector_addr_out = MAIN_BASE + {16'h0000, vec_q, 1'b0} +
                           (alt_sel ? ALT_OFS : 24'h000000);
  assign cpu_level_out = cpu_level;
  assign irq_out = |(evt_st_q & evt_msk_q);

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  flag_no_self_clear_a: assert property (
    !$past(|flag_wr) |-> ((~flag_q & $past(flag_q)) == '0))
    else $error("request flag cleared without a software write");
  flag_set_wins_a: assert property (
    |periph_req_in |=> ((flag_q & $past(periph_req_in)) == $past(periph_req_in)))
    else $error("peripheral request did not set its flag");
  enable_gate_a: assert property (
    ab.found |-> en_q[ab.irq_num] && flag_q[ab.irq_num])
    else $error("winner lacks enable or flag");
  winner_above_a: assert property (
    ab.found |-> {1'b0, ab.level} > cpu_level)
    else $error("winner not above cpu level");
  user_block_a: assert property (
    cpu_level >= 4'h7 |-> !ab.found)
    else $error("user interrupt allowed at level seven or above");
  latch_user_a: assert property (
    ab.found && !trap_found |=>
      vec_q == $past(ab.irq_num) + VEC_OFS && lvl_q == {1'b0, $past(ab.level)})
    else $error("pending vector or level latched wrongly");
  vec_range_a: assert property (
    int_req_q |-> vec_q <= LAST_VEC)
    else $error("pending vector beyond last used");
  table_addr_a: assert property (
    int_req_q && vec_q == 7'h44 |->
      vector_addr_out == (alt_sel ? 24'h00018c : 24'h00008c))
    else $error("vector table address wrong");
  high_bit_ro_a: assert property (
    reg_wr_in && reg_addr_in == A_CORE && !restore_in && !ack_take |=> $stable(cpu_high_q))
    else $error("software changed the high level bit");
  nest_ro_a: assert property (
    sr_wr && nest_dis && !restore_in && !ack_take |=> $stable(cpu_low_q))
    else $error("low level written while nesting disabled");

  user_taken_c: cover property (ab.found && !trap_found ##1 int_req_q ##1 ack_take);
  trap_taken_c: cover property (trap_found ##1 int_req_q && vec_q < VEC_OFS);
  alt_table_c: cover property (int_req_q && alt_sel);
  nest_block_c: cover property (sr_wr && nest_dis);
endmodule // vpic_ctrl

// File: design/vpic_pkg.sv
/*
  Constants of the vectored priority interrupt controller: register
  indices, field positions, reset values and source numbering.
  Assumes a 16-bit register port addressed by word index.
*/
package vpic_pkg;
  localparam int NUM_SRC = 72;
  localparam int NUM_EXT = 5;
  localparam int NUM_TRAP = 5;
  localparam int NUM_FLAG_REG = 5;
  localparam int NUM_PRI_REG = 18;
  localparam logic [6:0] VEC_OFS = 7'h08;
  localparam logic [6:0] LAST_VEC = 7'h4f;
  localparam logic [23:0] MAIN_BASE = 24'h000004;
  localparam logic [23:0] ALT_OFS = 24'h000100;
  // Register indices
  localparam logic [5:0] A_GC1 = 6'h00;
  localparam logic [5:0] A_GC2 = 6'h01;
  localparam logic [5:0] A_FLAG0 = 6'h02;
  localparam logic [5:0] A_EN0 = 6'h07;
  localparam logic [5:0] A_PRI0 = 6'h0c;
  localparam logic [5:0] A_PEND = 6'h1e;
  localparam logic [5:0] A_SR = 6'h1f;
  localparam logic [5:0] A_CORE = 6'h20;
  localparam logic [5:0] A_EVT_ST = 6'h21;
  localparam logic [5:0] A_EVT_MSK = 6'h22;
  // Field positions
  localparam int NEST_DIS_BIT = 15;
  localparam int ALT_SEL_BIT = 15;
  localparam int IPL_LSB = 5;
  localparam int IPL_HI_BIT = 3;
  localparam int TRAP_LSB = 1;
  localparam logic [15:0] GC1_WMASK = 16'hfffe;
  localparam logic [15:0] GC2_WMASK = 16'h801f;
  localparam int EVT_NEW = 0;
  localparam int EVT_TRAP = 1;
  localparam int EVT_W = 2;
  // Reset values
  localparam logic [15:0] GC_RST = 16'h0000;
  localparam logic [2:0] PRIO_RST = 3'h4;
  localparam logic [2:0] CPU_LOW_RST = 3'h0;
  localparam logic CPU_HIGH_RST = 1'b0;
  // External pins map to request numbers 0, 20, 29, 53, 54
  localparam int EXT_REQ [NUM_EXT] = '{0, 20, 29, 53, 54};
  // Trap inputs: osc fail, stack, address, math, dma error
  localparam int TRAP_VEC [NUM_TRAP] = '{1, 3, 2, 4, 5};
endpackage

// File: design/vpic_arb_if.sv
/*
  Carrier between the controller core and its priority arbiter.
  Assumes both ends share one clock; the arbiter is combinational.
*/
`timescale 1ns/100ps
interface vpic_arb_if;
  import vpic_pkg::*;
  logic [NUM_SRC-1:0] req;
  logic [2:0] prio [NUM_SRC];
  logic [3:0] cpu_level;
  logic found;
  logic [6:0] irq_num;
  logic [2:0] level;
  modport ctrl (output req, prio, cpu_level, input found, irq_num, level);
  modport arb (input req, prio, cpu_level, output found, irq_num, level);
endinterface

// File: design/vpic_pin_edge.sv
/*
  Synchroniser and edge detector for one external interrupt pin.
  Assumes the pin is asynchronous to core_clk_in.
*/
`timescale 1ns/100ps
module vpic_pin_edge (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  input wire logic neg_sel_in,
  output logic edge_out
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  assign edge_out = neg_sel_in ? (prev_q & ~sync2_q) : (~prev_q & sync2_q);
endmodule // vpic_pin_edge

// File: design/vpic_arbiter.sv
/*
  Priority arbiter: picks the pending source above the cpu level.
  Assumes req already holds flag and enable gating.
*/
`timescale 1ns/100ps
module vpic_arbiter
  import vpic_pkg::*;
(
  vpic_arb_if.arb bus
);
  logic found;
  logic [2:0] best;
  logic [6:0] num;
  always_comb begin
    found = 1'b0;
    best = 3'h0;
    num = 7'h00;
    // Strictly greater keeps the lower number on a tie
    for (int i = 0; i < NUM_SRC; i++) begin
      if (bus.req[i] && ({1'b0, bus.prio[i]} > bus.cpu_level) &&
          (!found || bus.prio[i] > best)) begin
        found = 1'b1;
        best = bus.prio[i];
        num = 7'(i);
      end
    end
  end
  assign bus.found = found;
  assign bus.level = best;
  assign bus.irq_num = num;
endmodule // vpic_arbiter

// File: tb/vpic_core_model.sv
/*
  Behavioural processor core facing the controller: takes a pending
  vector after a programmable wait, which raises the cpu level.
  Assumes the controller answers on core_clk_in with int_req held.
*/
`timescale 1ns/100ps
module vpic_core_model (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic take_en_in,
  input wire logic [3:0] delay_in,
  input wire logic int_req_in,
  output logic ack_out
);
  logic [3:0] wait_q;
  logic done_q;
  // One ack per request: a second ack before the drop would retake a stale vector
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_q <= 4'h0;
      ack_out <= 1'b0;
      done_q <= 1'b0;
    end else if (ack_out) begin
      ack_out <= 1'b0;
      done_q <= 1'b1;
      wait_q <= 4'h0;
    end else if (!int_req_in) begin
      done_q <= 1'b0;
    end else if (take_en_in && !done_q) begin
      if (wait_q >= delay_in) begin
        ack_out <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule // vpic_core_model

// File: tb/tb_top.sv
/*
  Self-checking bench of the interrupt controller against a model of
  flags, enables and priorities kept in integer arrays.
  Assumes vpic_pkg constants and the core model in vpic_core_model.sv.
*/
`timescale 1ns/100ps
module tb_top;
  import vpic_pkg::*;
  logic core_clk_in, reset_in, reg_wr, reg_rd, ack, restore, take_en, int_req, irq;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, rdata, d;
  logic [NUM_SRC-1:0] preq;
  logic [NUM_EXT-1:0] pins;
  logic [NUM_TRAP-1:0] traps;
  logic [3:0] rest_lvl, pend_lvl, cpu_lvl;
  logic [6:0] vnum;
  logic [23:0] vaddr;
  int n_errors, checks_done, seed, lvl, alt, a, b, pa, pb;
  int fl [NUM_SRC];
  int en [NUM_SRC];
  int pr [NUM_SRC];
  logic [5:0] ra [9] = '{A_GC1, A_GC2, A_FLAG0, A_EN0, A_PRI0, A_PEND, A_SR, A_CORE, 6'h3f};

  vpic_ctrl dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .periph_req_in(preq), .ext_pin_in(pins), .trap_in(traps), .ack_in(ack),
    .restore_in(restore), .restore_level_in(rest_lvl), .int_req_out(int_req),
    .vector_num_out(vnum), .pending_level_out(pend_lvl), .vector_addr_out(vaddr),
    .cpu_level_out(cpu_lvl), .irq_out(irq));
  vpic_core_model core (.core_clk_in(core_clk_in), .reset_in(reset_in), .take_en_in(take_en),
    .delay_in(4'h2), .int_req_in(int_req), .ack_out(ack));

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [15:0] v);
    @(posedge core_clk_in);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] ad);
    @(posedge core_clk_in);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk_in);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Two sources may share one pulse edge, which exercises the tie order
  task automatic pulse(input int x, input int y);
    logic [NUM_SRC-1:0] m;
    m = '0;
    m[x] = 1'b1;
    m[y] = 1'b1;
    fl[x] = 1;
    fl[y] = 1;
    @(posedge core_clk_in);
    preq <= m;
    @(posedge core_clk_in);
    preq <= '0;
  endtask
  task automatic set_src(input int n, input int e, input int p);
    logic [15:0] pw, ew;
    en[n] = e;
    pr[n] = p;
    pw = '0;
    ew = '0;
    for (int k = 0; k < 4; k++) pw[k*4 +: 3] = 3'(pr[n/4*4+k]);
    for (int k = 0; k < 16; k++) if (n/16*16+k < NUM_SRC) ew[k] = en[n/16*16+k][0];
    wr(A_EN0 + 6'(n/16), ew);
    wr(A_PRI0 + 6'(n/4), pw);
  endtask
  task automatic clr();
    for (int k = 0; k < NUM_FLAG_REG; k++) wr(A_FLAG0 + 6'(k), 16'h0);
    for (int k = 0; k < NUM_SRC; k++) fl[k] = 0;
  endtask
  task automatic set_lvl(input int l);
    @(posedge core_clk_in);
    restore <= 1'b1;
    rest_lvl <= 4'(l);
    @(posedge core_clk_in);
    restore <= 1'b0;
    lvl = l;
    #1;
    chk("cpu_level", 24'(l), 24'(cpu_lvl));
  endtask
  task automatic chk_pend();
    int w, bp;
    w = -1;
    bp = lvl;
    for (int n = 0; n < NUM_SRC; n++) if (fl[n] && en[n] && pr[n] > bp) begin
      bp = pr[n];
      w = n;
    end
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("int_req", 24'(w >= 0), 24'(int_req));
    if (w >= 0) begin
      chk("vector", 24'(w + 8), 24'(vnum));
      chk("level", 24'(pr[w]), 24'(pend_lvl));
      chk("addr", MAIN_BASE + 24'(2 * (w + 8)) + (alt ? ALT_OFS : 24'h0), vaddr);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  initial begin
    {reset_in, reg_wr, reg_rd, restore, take_en} = 5'h10;
    {reg_addr, reg_wdata, preq, pins, traps, rest_lvl} = '0;
    seed = 56213;
    lvl = 0;
    alt = 0;
    n_errors = 0;
    checks_done = 0;
    for (int k = 0; k < NUM_SRC; k++) begin
      fl[k] = 0;
      en[k] = 0;
      pr[k] = 4;
    end
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      rd(ra[k]);
      chk("reset_read", (ra[k] == A_PRI0) ? 24'h4444 : 24'h0, 24'(d));
    end
    set_src(60, 0, 4);
    pulse(60, 60);
    chk_pend();
    rd(A_FLAG0 + 6'h3);
    chk("flag60", 24'h1000, 24'(d));
    set_src(60, 1, 4);
    chk_pend();
    rd(A_PEND);
    chk("pend_reg", 24'h0444, 24'(d));
    wr(A_GC2, 16'h8000);
    alt = 1;
    chk_pend();
    take_en <= 1'b1;
    repeat (20) if (cpu_lvl !== 4'h4) @(negedge core_clk_in);
    take_en <= 1'b0;
    lvl = 4;
    chk("ack_level", 24'h4, 24'(cpu_lvl));
    chk_pend();
    rd(A_FLAG0 + 6'h3);
    chk("flag_kept", 24'h1000, 24'(d));
    clr();
    set_lvl(0);
    wr(A_GC2, 16'h0);
    alt = 0;
    set_src(71, 1, 7);
    pulse(71, 71);
    chk_pend();
    wr(A_SR, 16'h00c0);
    lvl = 6;
    chk_pend();
    wr(A_SR, 16'h00e0);
    lvl = 7;
    chk_pend();
    wr(A_GC1, 16'h8000);
    wr(A_SR, 16'h0000);
    rd(A_SR);
    chk("sr_locked", 24'h00e0, 24'(d & 16'h00e0));
    wr(A_GC1, 16'h0000);
    wr(A_CORE, 16'h0008);
    rd(A_CORE);
    chk("core_ro", 24'h0, 24'(d));
    set_lvl(8);
    chk_pend();
    rd(A_CORE);
    chk("core_hi", 24'h0008, 24'(d & 16'h0008));
    set_lvl(0);
    chk_pend();
    for (int i = 0; i < 8; i++) begin
      clr();
      a = {$random(seed)} % NUM_SRC;
      b = {$random(seed)} % NUM_SRC;
      pa = 1 + {$random(seed)} % 7;
      pb = (i < 2) ? pa : 1 + {$random(seed)} % 7;
      set_src(a, 1, pa);
      set_src(b, 1, pb);
      pulse(a, b);
      chk_pend();
    end
    // Idle level first, then the active edge, then the ignored edge back to idle
    for (int p = 0; p < 2; p++) begin
      wr(A_GC2, 16'(p));
      pins <= 5'(p);
      repeat (6) @(posedge core_clk_in);
      clr();
      pins <= 5'(p ^ 1);
      repeat (6) @(posedge core_clk_in);
      rd(A_FLAG0);
      chk("pin_edge", 24'h1, 24'(d & 16'h0001));
      clr();
      pins <= 5'(p);
      repeat (6) @(posedge core_clk_in);
      rd(A_FLAG0);
      chk("pin_quiet", 24'h0, 24'(d & 16'h0001));
    end
    wr(A_GC2, 16'h0);
    pins <= 5'h0;
    repeat (6) @(posedge core_clk_in);
    clr();
    wr(A_EVT_MSK, 16'h0001);
    wr(A_EVT_ST, 16'h0003);
    set_src(5, 1, 3);
    pulse(5, 5);
    chk_pend();
    chk("irq_on", 24'h1, 24'(irq));
    clr();
    wr(A_EVT_ST, 16'h0001);
    #1;
    chk("irq_off", 24'h0, 24'(irq));
    wr(A_EVT_MSK, 16'h0002);
    @(posedge core_clk_in);
    traps <= 5'h01;
    @(posedge core_clk_in);
    traps <= 5'h00;
    rd(A_GC1);
    chk("trap_flag", 24'h0002, 24'(d & 16'h003e));
    chk("trap_vector", 24'h1, 24'(vnum));
    chk("trap_level", 24'he, 24'(pend_lvl));
    chk("trap_addr", 24'h000006, vaddr);
    chk("irq_trap", 24'h1, 24'(irq));
    wr(A_GC1, 16'h0000);
    wr(A_EVT_ST, 16'h0002);
    #1;
    chk("irq_clr", 24'h0, 24'(irq));
    wrap_up();
  end
endmodule // tb_top
